// *** msp_midi_dev.sv ***
// Purpose: Behavioural instrument on the far side of the serial lines.
// Assumes: Bit period of BIT_CYC core clocks; line into the port pulled high.
// Notes:   Characters heard on the port's output queue in got_q.
`timescale 1ns/1ps
module msp_midi_dev
    import msp_pkg::*;
(
    // Clock.
    input  wire logic core_clk_i,
    // Serial lines.
    input  wire logic line_in_i,
    output logic      line_out_o
);
    logic [7:0] got_q[$];

    // The pull-up holds the line high between characters.
    initial line_out_o = 1'b1;

    task automatic send(input logic [7:0] b);
        logic [9:0] frm;
        frm = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out_o <= frm[i];
            repeat (BIT_CYC) @(posedge core_clk_i);
        end
    endtask : send

    initial begin
        logic [7:0] d;
        forever begin
            @(negedge line_in_i);
            repeat (HALF_CYC) @(posedge core_clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge core_clk_i);
                d[i] = line_in_i;
            end
            repeat (BIT_CYC) @(posedge core_clk_i);
            got_q.push_back(d);
        end
    end
endmodule : msp_midi_dev

// *** msp_midi_port.sv ***
// Purpose: Serial music port with pass-through and UART modes, command replies
//          and 16-byte receive and transmit FIFOs.
// Assumes: All inputs synchronous to core_clk_i; reset synchronous, active low.
// Notes:   Register reads answer in the cycle after the read strobe only.
// Function
// - Transmit and receive at fixed 31.25 kbit/s, no rate selection.
// - Frame is one start bit, eight data bits, one stop bit, no parity.
// - Reset gives pass-through with transmit off; data writes dropped unless enabled.
// - Pass-through receives into 16-byte FIFO; data read returns oldest entry.
// - Character arriving into full receive storage is dropped, old data kept.
// - Pass-through command 3Fh enters UART mode and queues FEh.
// - Commands A0h-A7h and ABh queue FEh then 00h.
// - Commands ACh, ADh, AFh queue FEh then 15h, 01h, 64h.
// - FFh resets port and flags then queues FEh; other commands queue FEh.
// - Acknowledge bytes behave like received bytes and clear receive-empty.
// - Entering UART with FIFO disabled drops stored data; receive blocked until read.
// - Commands wait until any started character has finished.
// - UART mode enables transmit, receive and both 16-byte FIFOs.
// - UART data writes enter transmit FIFO; engine sends while data remains.
// - UART FFh returns to initial pass-through; other commands ignored.
// - Leaving UART drops receive FIFO unless pass-through FIFO enabled.
// - Status bit 7 receive empty, bit 6 transmit full; reads leave them.
// - Status bits 5 and 2 track FIFOs only in FIFO modes, else zero.
// - Status bit 3 set on overrun in either mode; cleared by status read.
// - Status bit 4 shows the current operating mode.
`timescale 1ns/1ps
module msp_midi_port #(
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic                  core_clk_i,
    input  wire logic                  rstn_i,
    // Register port.
    input  wire msp_pkg::msp_bus_req_t bus_req_i,
    output logic [msp_pkg::DATA_W-1:0] rdata_o,
    // Serial lines.
    input  wire logic                  serial_in_pin_i,
    output logic                       serial_out_pin_o
);
    import msp_pkg::*;

    localparam int           AW       = $clog2(DEPTH);
    localparam logic [AW:0]  LIM_FULL = (AW + 1)'(DEPTH);
    localparam logic [AW:0]  LIM_ONE  = (AW + 1)'(1);

    // Reply byte for a pass-through command: flag in bit 8, data below.
    function automatic logic [8:0] cmd_reply(input logic [7:0] code);
        logic [8:0] r;
        r = {1'b0, RPL_ZERO};
        if ((code >= CMD_ZERO_L && code <= CMD_ZERO_H) || code == CMD_ZERO_X) begin
            r = {1'b1, RPL_ZERO};
        end else if (code == CMD_VER) begin
            r = {1'b1, RPL_VER};
        end else if (code == CMD_REV) begin
            r = {1'b1, RPL_REV};
        end else if (code == CMD_SPEED) begin
            r = {1'b1, RPL_SPEED};
        end
        return r;
    endfunction : cmd_reply

    // Mode, control and flags.
    logic          uart_mode, ovr, rx_block, cmd_pend, reply_pend;
    logic [7:0]    ctl, cmd_code, reply_byte;
    // FIFO storage and pointers.
    logic [7:0]    rx_mem [DEPTH];
    logic [7:0]    tx_mem [DEPTH];
    logic [AW-1:0] rx_rd, rx_wr, tx_rd, tx_wr;
    logic [AW:0]   rx_cnt, tx_cnt;
    // Serial engines.
    msp_rx_state_t    rx_state;
    msp_tx_state_t    tx_state;
    logic [CNT_W-1:0] rx_tmr, tx_tmr;
    logic [2:0]       rx_idx, tx_idx;
    logic [7:0]       rx_shift, tx_shift;
    logic             rx_prev, rx_done;
    // Decoded strobes and derived terms.
    logic       wr_data, wr_cmd, wr_ctl, rd_data, rd_stat;
    logic       fifo_mode, rx_full, tx_full, tx_allow;
    logic       cmd_exec, soft_rst, rx_flush, ack_push;
    logic       rx_req, rx_push, rx_pop, tx_push, tx_pop;
    logic [7:0] rx_req_data;
    logic [7:0] status_word;
    logic [AW:0] lim;

    // Access decode.
    assign wr_data = bus_req_i.wr && bus_req_i.addr == OFS_DATA;
    assign wr_cmd  = bus_req_i.wr && bus_req_i.addr == OFS_STAT_CMD;
    assign wr_ctl  = bus_req_i.wr && bus_req_i.addr == OFS_CTRL;
    assign rd_data = bus_req_i.rd && bus_req_i.addr == OFS_DATA;
    assign rd_stat = bus_req_i.rd && bus_req_i.addr == OFS_STAT_CMD;

    // FIFO depth follows the mode; without FIFOs each side is one byte deep.
    // FIFOs in UART
    assign fifo_mode = uart_mode || ctl[CTL_PT_FIFO_BIT];
    assign lim       = fifo_mode ? LIM_FULL : LIM_ONE;
    assign rx_full   = rx_cnt >= lim;
    assign tx_full   = tx_cnt >= lim;
    assign tx_allow  = uart_mode || ctl[CTL_TX_EN_BIT];

    assign cmd_exec = cmd_pend && rx_state == RX_IDLE && tx_state == TX_IDLE && !rx_done;
    assign soft_rst = cmd_exec && cmd_code == CMD_RESET;
    assign ack_push = cmd_exec && !uart_mode;

    // Flush: pass-through reset, entering UART without FIFO, leaving UART without FIFO.
    // drop on entry
    always_comb begin
        rx_flush = 1'b0;
        if (cmd_exec && !uart_mode) begin
            rx_flush = cmd_code == CMD_RESET ||
                       (cmd_code == CMD_UART && !ctl[CTL_PT_FIFO_BIT]);
        end else if (soft_rst) begin
            rx_flush = !ctl[CTL_PT_FIFO_BIT];
        end
    end

    // Receive-side push source: serial byte, acknowledge, then reply byte.
    // acknowledge as data
    always_comb begin
        rx_req      = 1'b0;
        rx_req_data = rx_shift;
        if (rx_done && !rx_block) begin
            rx_req = 1'b1;
        end else if (ack_push) begin
            rx_req      = 1'b1;
            rx_req_data = ACK_BYTE;
        end else if (reply_pend) begin
            rx_req      = 1'b1;
            rx_req_data = reply_byte;
        end
    end

    assign rx_push = rx_req && (!rx_full || rx_flush);
    assign rx_pop  = rd_data && rx_cnt != '0 && !rx_flush;
    assign tx_push = wr_data && tx_allow && !tx_full && !soft_rst;
    assign tx_pop  = tx_state == TX_IDLE && tx_cnt != '0 && tx_allow && !cmd_exec;

    // Status image assembled from live state.
    always_comb begin
        status_word = 8'h00;
        status_word[ST_RX_EMPTY_BIT] = rx_cnt == '0;
        status_word[ST_TX_FULL_BIT]  = tx_full;
        status_word[ST_RX_FFULL_BIT] = fifo_mode && rx_full;
        status_word[ST_TX_FEMPT_BIT] = fifo_mode && tx_cnt == '0;
        status_word[ST_MODE_BIT]     = uart_mode;
        status_word[ST_OVR_BIT]      = ovr;
    end

    // Command capture and execution bookkeeping.
    // command by write
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cmd_pend <= 1'b0;
            cmd_code <= 8'h00;
        end else if (wr_cmd) begin
            cmd_pend <= 1'b1;
            cmd_code <= bus_req_i.wdata;
        end else if (cmd_exec) begin
            cmd_pend <= 1'b0;
        end
    end

    // Operating mode.
    // enter UART
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || soft_rst) begin
            uart_mode <= 1'b0;
        end else if (cmd_exec && !uart_mode && cmd_code == CMD_UART) begin
            uart_mode <= 1'b1;
        end
    end

    // Reply byte queued one cycle after the acknowledge.
    // zero reply
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            {reply_pend, reply_byte} <= 9'h000;
        end else begin
            // The flag only survives when this cycle queues an acknowledge.
            {reply_pend, reply_byte} <= cmd_reply(cmd_code) & {ack_push, 8'hff};
        end
    end

    // Receive block after entering UART lasts until the next data read.
    // block until read
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || soft_rst) begin
            rx_block <= 1'b0;
        end else if (cmd_exec && !uart_mode && cmd_code == CMD_UART) begin
            rx_block <= 1'b1;
        end else if (rx_pop) begin
            rx_block <= 1'b0;
        end
    end

    // Control register; the reset command restores its initial value.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || soft_rst) begin
            ctl <= CTL_RST;
        end else if (wr_ctl) begin
            ctl <= bus_req_i.wdata;
        end
    end

    // Overrun flag; a new overrun wins over the read that clears it.
    // overrun sticky
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ovr <= 1'b0;
        end else begin
            ovr <= (ovr && !rd_stat && !soft_rst) || (rx_req && !rx_push);
        end
    end

    // Register read data, valid for one cycle after the strobe.
    // oldest entry
    always_ff @(posedge core_clk_i) begin
        rdata_o <= 8'h00;
        if (rstn_i && bus_req_i.rd) begin
            case (bus_req_i.addr)
                OFS_DATA:     rdata_o <= (rx_cnt != '0) ? rx_mem[rx_rd] : 8'h00;
                OFS_STAT_CMD: rdata_o <= status_word;
                OFS_CTRL:     rdata_o <= ctl;
                default:      rdata_o <= 8'h00;
            endcase
        end
    end

    // Receive FIFO storage; a flush restarts writing at slot zero.
    always_ff @(posedge core_clk_i) begin
        if (rx_push) begin
            rx_mem[rx_flush ? '0 : rx_wr] <= rx_req_data;
        end
    end

    // Receive FIFO pointers and fill level.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            rx_rd  <= '0;
            rx_wr  <= '0;
            rx_cnt <= '0;
        end else if (rx_flush) begin
            rx_rd  <= '0;
            rx_wr  <= rx_push ? AW'(1) : '0;
            rx_cnt <= rx_push ? LIM_ONE : '0;
        end else begin
            if (rx_push) rx_wr <= rx_wr + 1'b1;
            if (rx_pop)  rx_rd <= rx_rd + 1'b1;
            case ({rx_push, rx_pop})
                2'b10:   rx_cnt <= rx_cnt + 1'b1;
                2'b01:   rx_cnt <= rx_cnt - 1'b1;
                default: rx_cnt <= rx_cnt;
            endcase
        end
    end

    // Transmit FIFO storage.
    always_ff @(posedge core_clk_i) begin
        if (tx_push) begin
            tx_mem[tx_wr] <= bus_req_i.wdata;
        end
    end

    // Transmit FIFO pointers and fill level; emptied by the reset command.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || soft_rst) begin
            tx_rd  <= '0;
            tx_wr  <= '0;
            tx_cnt <= '0;
        end else begin
            if (tx_push) tx_wr <= tx_wr + 1'b1;
            if (tx_pop)  tx_rd <= tx_rd + 1'b1;
            case ({tx_push, tx_pop})
                2'b10:   tx_cnt <= tx_cnt + 1'b1;
                2'b01:   tx_cnt <= tx_cnt - 1'b1;
                default: tx_cnt <= tx_cnt;
            endcase
        end
    end

    // Receiver: half-bit wait after the falling edge, then one bit per period.
    // centre sampling
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            rx_state <= RX_IDLE;
            rx_tmr   <= '0;
            rx_idx   <= 3'h0;
            rx_shift <= 8'h00;
            rx_prev  <= 1'b1;
            rx_done  <= 1'b0;
        end else begin
            rx_prev <= serial_in_pin_i;
            rx_done <= 1'b0;
            if (rx_state != RX_IDLE && rx_tmr != '0) begin
                rx_tmr <= rx_tmr - 1'b1;
            end else begin
                case (rx_state)
                    RX_IDLE: begin
                        if (rx_prev && !serial_in_pin_i) begin
                            rx_state <= RX_START;
                            rx_tmr   <= HALF_LAST;
                        end
                    end
                    RX_START: begin
                        // A glitch that is high again at mid-bit is no start.
                        rx_state <= serial_in_pin_i ? RX_IDLE : RX_DATA;
                        rx_tmr   <= BIT_LAST;
                        rx_idx   <= 3'h0;
                    end
                    RX_DATA: begin
                        rx_shift <= {serial_in_pin_i, rx_shift[7:1]};
                        rx_idx   <= rx_idx + 1'b1;
                        rx_tmr   <= BIT_LAST;
                        if (rx_idx == LAST_BIT) rx_state <= RX_STOP;
                    end
                    RX_STOP: begin
                        // A low stop bit marks a broken frame, which is dropped.
                        rx_done  <= serial_in_pin_i;
                        rx_state <= RX_IDLE;
                    end
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // Transmitter: start bit, eight data bits, stop bit, line idles high.
    // send while data
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            tx_state         <= TX_IDLE;
            tx_tmr           <= '0;
            tx_idx           <= 3'h0;
            tx_shift         <= 8'h00;
            serial_out_pin_o <= 1'b1;
        end else if (tx_state != TX_IDLE && tx_tmr != '0) begin
            tx_tmr <= tx_tmr - 1'b1;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    serial_out_pin_o <= 1'b1;
                    if (tx_pop) begin
                        tx_shift         <= tx_mem[tx_rd];
                        serial_out_pin_o <= 1'b0;
                        tx_tmr           <= BIT_LAST;
                        tx_state         <= TX_START;
                    end
                end
                TX_START: begin
                    serial_out_pin_o <= tx_shift[0];
                    tx_shift         <= {1'b0, tx_shift[7:1]};
                    tx_idx           <= 3'h0;
                    tx_tmr           <= BIT_LAST;
                    tx_state         <= TX_DATA;
                end
                TX_DATA: begin
                    tx_tmr <= BIT_LAST;
                    if (tx_idx == LAST_BIT) begin
                        serial_out_pin_o <= 1'b1;
                        tx_state         <= TX_STOP;
                    end else begin
                        serial_out_pin_o <= tx_shift[0];
                        tx_shift         <= {1'b0, tx_shift[7:1]};
                        tx_idx           <= tx_idx + 1'b1;
                    end
                end
                TX_STOP: begin
                    tx_state <= TX_IDLE;
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

endmodule : msp_midi_port

// *** msp_midi_port_tb.sv ***
// Purpose: Self-checking bench of the serial music port.
// Assumes: FIFOs shrunk to two entries so that overflow comes quickly.
// Notes:   Command replies run from a table; serial cases follow by hand.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module msp_midi_port_tb;
    import msp_pkg::*;
    logic              core_clk_i;
    logic              rstn_i;
    msp_bus_req_t      bus_req_i;
    logic [DATA_W-1:0] rdata_o;
    logic              serial_in_pin_i;
    logic              serial_out_pin_o;
    int                n_mismatch;
    int                check_count;
    logic [7:0]        v;
    // Command code, reply flag and reply byte of each row.
    localparam logic [16:0] ROWS [13] = '{{8'ha0, 9'h100}, {8'ha1, 9'h100},
        {8'ha2, 9'h100}, {8'ha3, 9'h100}, {8'ha4, 9'h100}, {8'ha5, 9'h100},
        {8'ha6, 9'h100}, {8'ha7, 9'h100}, {8'hab, 9'h100}, {8'hac, 9'h115},
        {8'had, 9'h101}, {8'haf, 9'h164}, {8'h12, 9'h000}};

    msp_midi_port #(.DEPTH(2)) dut (
        .core_clk_i       (core_clk_i),
        .rstn_i           (rstn_i),
        .bus_req_i        (bus_req_i),
        .rdata_o          (rdata_o),
        .serial_in_pin_i  (serial_in_pin_i),
        .serial_out_pin_o (serial_out_pin_o)
    );

    msp_midi_dev dev (
        .core_clk_i (core_clk_i),
        .line_in_i  (serial_out_pin_o),
        .line_out_o (serial_in_pin_i)
    );

    // Free-running 40 MHz clock.
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : cyc

    // One write cycle, then one idle cycle before the next strobe.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        bus_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        bus_req_i <= '0;
        @(posedge core_clk_i);
    endtask : wr

    // One read cycle; the answer is taken in the cycle after the strobe.
    task automatic rchk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string nm);
        bus_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        bus_req_i <= '0;
        #1;
        `CHK(nm, e, rdata_o & m)
        @(posedge core_clk_i);
    endtask : rchk

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // Cuts a hang short past the expected run of some 92k cycles.
    initial begin
        cyc(99000);
        n_mismatch++;
        close_out();
    end

    // Main sequence: table of commands, then the hand-written cases.
    initial begin
        bus_req_i   = '0;
        rstn_i      = 1'b0;
        n_mismatch  = 0;
        check_count = 0;
        cyc(16);
        rstn_i <= 1'b1;
        cyc(2);
        rchk(OFS_STAT_CMD, 8'hff, 8'h84, "status");
        rchk(OFS_CTRL, 8'hff, CTL_RST, "control");
        rchk(2'h3, 8'hff, 8'h00, "unmapped");
        $display("test reset done");
        foreach (ROWS[i]) begin
            wr(OFS_STAT_CMD, ROWS[i][16:9]);
            cyc(2);
            rchk(OFS_DATA, 8'hff, ACK_BYTE, "ack");
            if (ROWS[i][8])
                rchk(OFS_DATA, 8'hff, ROWS[i][7:0], "reply");
            rchk(OFS_STAT_CMD, 8'h90, 8'h80, "drained");
        end
        $display("test commands done");
        wr(OFS_DATA, 8'h3c);
        cyc(200);
        `CHK("tx off", 1'b1, serial_out_pin_o)
        wr(OFS_CTRL, CTL_RST | 8'h10);
        wr(OFS_DATA, 8'ha5);
        cyc(BIT_CYC * 11);
        `CHK("tx count", 1, dev.got_q.size())
        v = dev.got_q.pop_front();
        `CHK("tx byte", 8'ha5, v)
        $display("test transmit done");
        dev.send(8'h81);
        dev.send(8'h42);
        dev.send(8'h18);
        cyc(8);
        rchk(OFS_STAT_CMD, 8'hf8, 8'h28, "overrun");
        rchk(OFS_STAT_CMD, 8'hf8, 8'h20, "cleared");
        rchk(OFS_DATA, 8'hff, 8'h81, "rx first");
        rchk(OFS_DATA, 8'hff, 8'h42, "rx second");
        $display("test receive done");
        fork
            dev.send(8'h6d);
        join_none
        cyc(2000);
        wr(OFS_STAT_CMD, 8'h12);
        cyc(20);
        rchk(OFS_STAT_CMD, 8'h80, 8'h80, "deferred");
        cyc(BIT_CYC * 9);
        rchk(OFS_DATA, 8'hff, 8'h6d, "rx byte");
        rchk(OFS_DATA, 8'hff, ACK_BYTE, "late ack");
        $display("test deferral done");
        wr(OFS_STAT_CMD, CMD_UART);
        cyc(2);
        rchk(OFS_DATA, 8'hff, ACK_BYTE, "uart ack");
        wr(OFS_STAT_CMD, CMD_ZERO_L);
        cyc(4);
        rchk(OFS_STAT_CMD, 8'h90, 8'h90, "uart mode");
        wr(OFS_DATA, 8'h01);
        wr(OFS_DATA, 8'hc3);
        cyc(BIT_CYC * 20);
        `CHK("uart count", 2, dev.got_q.size())
        v = dev.got_q.pop_front();
        `CHK("uart first", 8'h01, v)
        v = dev.got_q.pop_front();
        `CHK("uart second", 8'hc3, v)
        wr(OFS_STAT_CMD, CMD_RESET);
        cyc(4);
        rchk(OFS_STAT_CMD, 8'hfb, 8'h80, "back");
        rchk(OFS_CTRL, 8'hff, CTL_RST, "ctrl back");
        $display("test uart done");
        // One-byte buffers: no FIFO flags, and entering UART drops the old byte.
        wr(OFS_CTRL, 8'h00);
        wr(OFS_STAT_CMD, 8'h12);
        rchk(OFS_STAT_CMD, 8'hff, 8'h00, "no fifo flags");
        wr(OFS_STAT_CMD, CMD_UART);
        cyc(2);
        rchk(OFS_DATA, 8'hff, ACK_BYTE, "one ack");
        rchk(OFS_STAT_CMD, 8'hf8, 8'h90, "flushed");
        $display("test no fifo done");
        close_out();
    end
endmodule : msp_midi_port_tb

// *** msp_pkg.sv ***
// Purpose: Shared constants, types and state sets of the serial music port.
// Assumes: Core clock of 40 MHz; register port with two address bits.
// Notes:   Every offset, field position, command code and timing count lives here.
package msp_pkg;

    // Register port geometry and offsets.
    localparam int         DATA_W       = 8;
    localparam int         ADDR_W       = 2;
    localparam logic [1:0] OFS_DATA     = 2'h0;
    localparam logic [1:0] OFS_STAT_CMD = 2'h1;
    localparam logic [1:0] OFS_CTRL     = 2'h2;

    // Control register fields and reset value.
    localparam int         CTL_TX_EN_BIT   = 4;
    localparam int         CTL_PT_FIFO_BIT = 5;
    localparam logic [7:0] CTL_RST         = 8'h20;

    // Status register field positions.
    localparam int ST_RX_EMPTY_BIT = 7;
    localparam int ST_TX_FULL_BIT  = 6;
    localparam int ST_RX_FFULL_BIT = 5;
    localparam int ST_MODE_BIT     = 4;
    localparam int ST_OVR_BIT      = 3;
    localparam int ST_TX_FEMPT_BIT = 2;

    // Command codes and the bytes queued in reply.
    localparam logic [7:0] CMD_UART   = 8'h3f;
    localparam logic [7:0] CMD_RESET  = 8'hff;
    localparam logic [7:0] CMD_ZERO_L = 8'ha0;
    localparam logic [7:0] CMD_ZERO_H = 8'ha7;
    localparam logic [7:0] CMD_ZERO_X = 8'hab;
    localparam logic [7:0] CMD_VER    = 8'hac;
    localparam logic [7:0] CMD_REV    = 8'had;
    localparam logic [7:0] CMD_SPEED  = 8'haf;
    localparam logic [7:0] ACK_BYTE   = 8'hfe;
    localparam logic [7:0] RPL_ZERO   = 8'h00;
    localparam logic [7:0] RPL_VER    = 8'h15;
    localparam logic [7:0] RPL_REV    = 8'h01;
    localparam logic [7:0] RPL_SPEED  = 8'h64;

    // Bit timing: 31.25 kbit/s from the core clock.
    localparam int CLK_HZ   = 40_000_000;
    localparam int BAUD_BPS = 31_250;
    localparam int BIT_CYC  = CLK_HZ / BAUD_BPS;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam int CNT_W    = $clog2(BIT_CYC + 1);
    localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
    localparam logic [2:0]       LAST_BIT  = 3'h7;

    // One register access from the host.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } msp_bus_req_t;

    // Serial engine states.
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} msp_rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} msp_tx_state_t;

endpackage : msp_pkg

// *** msp_port_properties.sv ***
// Purpose: Port-level checks of the serial music port.
// Assumes: One clock domain; reset synchronous, active low.
// Notes:   A frame counter follows each character on the transmit line.
`timescale 1ns/1ps
module msp_port_checker
    import msp_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic                       core_clk_i,
    input wire logic                       rstn_i,
    // Register port and serial lines.
    input wire msp_pkg::msp_bus_req_t      bus_req_i,
    input wire logic [msp_pkg::DATA_W-1:0] rdata_o,
    input wire logic                       serial_in_pin_i,
    input wire logic                       serial_out_pin_o
);
    logic [13:0] frm_cnt;
    logic        tx_q;

    // Counts cycles since a start bit began on the transmit line.
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            frm_cnt <= '0;
            tx_q    <= 1'b1;
        end else begin
            tx_q <= serial_out_pin_o;
            if (frm_cnt != '0)
                frm_cnt <= (frm_cnt == 14'(10 * BIT_CYC)) ? '0 : frm_cnt + 14'h1;
            else if (tx_q && !serial_out_pin_o)
                frm_cnt <= 14'h1;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    rdata_idle_a: assert property (!bus_req_i.rd |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read answer");
    stat_low_a: assert property (bus_req_i.rd && bus_req_i.addr == OFS_STAT_CMD
        |=> rdata_o[1:0] == 2'b00) else $error("status low bits not zero");
    unmapped_rd_a: assert property (bus_req_i.rd && bus_req_i.addr == 2'h3
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    reset_idle_a: assert property ($rose(rstn_i) |-> serial_out_pin_o)
        else $error("transmit line not idle after reset");
    bit_edge_a: assert property (frm_cnt != '0 && serial_out_pin_o != tx_q
        |-> int'(frm_cnt) % BIT_CYC == 0) else $error("bit edge off the bit grid");
    start_low_a: assert property (frm_cnt inside {[1:1279]} |-> !serial_out_pin_o)
        else $error("start bit not held low");
    stop_high_a: assert property (frm_cnt >= 14'(9 * BIT_CYC) |-> serial_out_pin_o)
        else $error("stop bit not high");
    idle_only_a: assert property (frm_cnt == '0 && $changed(serial_out_pin_o)
        |-> !serial_out_pin_o) else $error("line rose outside a frame");
endmodule : msp_port_checker

bind msp_midi_port msp_port_checker #(.DEPTH(DEPTH)) u_chk (
    .core_clk_i       (core_clk_i),
    .rstn_i           (rstn_i),
    .bus_req_i        (bus_req_i),
    .rdata_o          (rdata_o),
    .serial_in_pin_i  (serial_in_pin_i),
    .serial_out_pin_o (serial_out_pin_o)
);
